// >>> logic/smc_pkg.sv
// Purpose: constants for the system integration register group
// Assumes: 16-bit registers, each at one 32-bit APB word
// Notes: byte address of a register is four times its index
package smc_pkg;

  localparam int ADDR_WIDTH = 12;
  localparam int INDEX_WIDTH = 10;
  localparam int REG_WIDTH = 16;

  // Register indices; byte address is index * 4
  localparam logic [9:0] IDX_SCRATCH_WORD_0 = 10'h002;
  localparam logic [9:0] IDX_SCRATCH_WORD_1 = 10'h003;
  localparam logic [9:0] IDX_SCRATCH_WORD_2 = 10'h004;
  localparam logic [9:0] IDX_SCRATCH_WORD_3 = 10'h005;
  localparam logic [9:0] IDX_CHIP_ID_UPPER = 10'h006;
  localparam logic [9:0] IDX_CHIP_ID_LOWER = 10'h007;
  localparam logic [9:0] IDX_PULLUP_DISABLE = 10'h008;
  localparam logic [9:0] IDX_CLOCK_OUT_SELECT = 10'h00a;
  localparam int NUM_SCRATCH = 4;

  // Reset values
  localparam logic [15:0] SCRATCH_RESET = 16'h0000;
  localparam logic [15:0] PULLUP_RESET = 16'h0000;
  localparam logic [15:0] CLKOSR_RESET = 16'h0020;

  // Writable bits; everything else reads as zero
  localparam logic [15:0] PULLUP_MASK = 16'h7fa8;
  localparam logic [15:0] CLKOSR_MASK = 16'h03ff;

  // Pull-up disable bit positions
  localparam int PU_PWM_A_FAULT3 = 14;
  localparam int PU_CAN_RX = 13;
  localparam int PU_MEMORY_MODE = 12;
  localparam int PU_RESET_PIN = 11;
  localparam int PU_IRQ_PINS = 10;
  localparam int PU_BOOT_SELECT = 9;
  localparam int PU_PWM_B_FAULT = 8;
  localparam int PU_PWM_A_FAULT_LOW = 7;
  localparam int PU_STROBES = 5;
  localparam int PU_JTAG = 3;

  // Clock-out select fields
  localparam int CO_PB_ALT_LSB = 6;
  localparam int CO_TRISTATE = 5;
  localparam int CO_SEL_MSB = 4;

  // Clock-out source codes
  localparam logic [4:0] SEL_SYSTEM_CLOCK = 5'h00;
  localparam logic [4:0] SEL_OSC_OUT = 5'h07;
  localparam logic [4:0] SEL_PLL_OUT = 5'h08;
  localparam logic [4:0] SEL_CONV_A = 5'h10;
  localparam logic [4:0] SEL_CONV_B = 5'h11;
  localparam int NUM_TEST_CLK = 13;

endpackage

// >>> logic/smc_regs.sv
// Contract
// (R1) Scratch words cleared by power-on reset only
// (R2) Four scratch words at offsets 2 to 5
// (R3) Constant upper chip ID at 6
// (R4) Constant lower chip ID at 7, writes ignored
// (R5) Set pull-up bit disables group pull-ups
// (R6) Bits 14, 8, 7 cover fault inputs
// (R7) Bits 13,12,11,10,9,5,3 cover other pin groups
// (R8) Reserved bits read zero, ignore writes
// (R9) GPIO enable first, then alternate select
// (R10) Bit 9: address 23 or oscillator
// (R11) Bit 8: address 22 or secondary clock
// (R12) Bit 7: address 21 or system clock
// (R13) Bit 6: address 20 or prescaler clock
// (R14) Alternate selects reset to address lines
// (R15) Bit 5 tri-states clock out, resets set
// (R16) Five-bit select picks clock-out source
// (R17) Test codes route internal test clocks
// (R18) Undocumented codes drive constant low
//
// Purpose: system integration register group on APB
// Assumes: clock inputs arrive from other domains and are sampled
// Notes: outputs are registered; sampled clocks are MCLK-rate copies
`timescale 1ns/1ps

module smc_regs #(
  parameter logic [15:0] CHIP_ID_UPPER = 16'h0a5a, // Arbitrary value
  parameter logic [15:0] CHIP_ID_LOWER = 16'h5a0a  // Arbitrary value
) (
  // Clock and resets
  input wire logic MCLK,
  input wire logic RST,
  input wire logic POR_RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Port B upper pins, pins 7 to 4 as bits 3 to 0
  input wire logic [3:0] PORT_B_PERIPHERAL_ENABLE,
  input wire logic [3:0] PORT_B_GPIO_OUT,
  input wire logic [3:0] HIGH_ADDRESS,
  output logic [3:0] PORT_B_OUT,
  // Clock sources
  input wire logic SYSTEM_CLOCK,
  input wire logic SECONDARY_SYSTEM_CLOCK,
  input wire logic RAW_OSCILLATOR_CLOCK,
  input wire logic PRESCALER_REFERENCE_CLOCK,
  input wire logic OSC_OUT_CLOCK,
  input wire logic PLL_OUT_CLOCK,
  input wire logic CONV_A_CLOCK,
  input wire logic CONV_B_CLOCK,
  input wire logic [12:0] TEST_CLOCKS,
  // Clock-out pin
  output logic CLOCK_OUT_PIN_O,
  output logic CLOCK_OUT_PIN_OE,
  // Pull-up disables
  output logic [15:0] PULLUP_OFF
);

  logic any_rst;
  logic [20:0] clk_meta;
  logic [20:0] clk_sync;
  logic [15:0] scratch [smc_pkg::NUM_SCRATCH];
  logic [15:0] pullup_disable;
  logic [15:0] clock_out_select;
  logic [9:0] index;
  logic setup;
  logic commit;
  logic [15:0] wdata;
  logic [15:0] next_rdata;
  logic next_err;
  logic next_clock_out_driver;
  logic [3:0] next_pb;

  // System reset and power-on reset both load the reset values into the control registers
  assign any_rst = RST | POR_RST;
  assign index = PADDR[11:2];
  assign setup = PSEL & ~PENABLE;
  assign commit = PSEL & PENABLE & PREADY & PWRITE & ~PSLVERR;
  assign wdata = PWDATA[15:0];

  function automatic logic mapped(input logic [11:0] addr);
    logic [9:0] idx;
    idx = addr[11:2];
    mapped = (addr[1:0] == 2'b00) &&
             ((idx >= smc_pkg::IDX_SCRATCH_WORD_0 &&
               idx <= smc_pkg::IDX_PULLUP_DISABLE) ||
              idx == smc_pkg::IDX_CLOCK_OUT_SELECT);
  endfunction

  // Clocks are foreign to MCLK; two flops before any use
  always_ff @(posedge MCLK or posedge any_rst) begin
    if (any_rst) begin
      clk_meta <= '0;
      clk_sync <= '0;
    end else begin
      clk_meta <= {TEST_CLOCKS, CONV_B_CLOCK, CONV_A_CLOCK, PLL_OUT_CLOCK,
                   OSC_OUT_CLOCK, PRESCALER_REFERENCE_CLOCK,
                   RAW_OSCILLATOR_CLOCK, SECONDARY_SYSTEM_CLOCK,
                   SYSTEM_CLOCK};
      clk_sync <= clk_meta;
    end
  end

  // Scratch words see only power-on reset so software data survives
  // pin, software and watchdog resets
  genvar g;
  generate
    for (g = 0; g < smc_pkg::NUM_SCRATCH; g++) begin : g_scratch
      always_ff @(posedge MCLK or posedge POR_RST) begin
        if (POR_RST) begin
          scratch[g] <= smc_pkg::SCRATCH_RESET; // R1
        end else if (commit &&
                     index == smc_pkg::IDX_SCRATCH_WORD_0 + 10'(g)) begin
          scratch[g] <= wdata; // R2
        end
      end
    end
  endgenerate

  always_ff @(posedge MCLK or posedge any_rst) begin
    if (any_rst) begin
      pullup_disable <= smc_pkg::PULLUP_RESET; // R5
    end else if (commit && index == smc_pkg::IDX_PULLUP_DISABLE) begin
      pullup_disable <= wdata & smc_pkg::PULLUP_MASK; // R8
    end
  end

  always_ff @(posedge MCLK or posedge any_rst) begin
    if (any_rst) begin
      clock_out_select <= smc_pkg::CLKOSR_RESET; // R14 R15
    end else if (commit && index == smc_pkg::IDX_CLOCK_OUT_SELECT) begin
      clock_out_select <= wdata & smc_pkg::CLKOSR_MASK; // R8
    end
  end

  // Read mux; ID words are constants and never written
  always_comb begin
    next_rdata = 16'h0000;
    unique case (index)
      smc_pkg::IDX_SCRATCH_WORD_0: next_rdata = scratch[0];
      smc_pkg::IDX_SCRATCH_WORD_1: next_rdata = scratch[1];
      smc_pkg::IDX_SCRATCH_WORD_2: next_rdata = scratch[2];
      smc_pkg::IDX_SCRATCH_WORD_3: next_rdata = scratch[3];
      smc_pkg::IDX_CHIP_ID_UPPER: next_rdata = CHIP_ID_UPPER; // R3
      smc_pkg::IDX_CHIP_ID_LOWER: next_rdata = CHIP_ID_LOWER; // R4
      smc_pkg::IDX_PULLUP_DISABLE: next_rdata = pullup_disable;
      smc_pkg::IDX_CLOCK_OUT_SELECT: next_rdata = clock_out_select;
      default: next_rdata = 16'h0000;
    endcase
    next_err = ~mapped(PADDR);
  end

  // Answer is prepared at the setup edge so the bus outputs are flops;
  // PREADY is already high in the first access cycle, so there is no wait state
  always_ff @(posedge MCLK or posedge any_rst) begin
    if (any_rst) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (setup) begin
      PREADY <= 1'b1;
      PRDATA <= PWRITE || next_err ? 32'h0000_0000 : {16'h0000, next_rdata};
      PSLVERR <= next_err;
    end else begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end
  end

  // Clock-out source; sync bits: 0 sys, 4 osc, 5 pll, 6/7 conv, 8+ test
  always_comb begin
    logic [4:0] sel;
    sel = clock_out_select[smc_pkg::CO_SEL_MSB:0];
    next_clock_out_driver = 1'b0; // R18
    if (sel == smc_pkg::SEL_SYSTEM_CLOCK) begin
      next_clock_out_driver = clk_sync[0]; // R16
    end else if (sel == smc_pkg::SEL_OSC_OUT) begin
      next_clock_out_driver = clk_sync[4]; // R16
    end else if (sel == smc_pkg::SEL_PLL_OUT) begin
      next_clock_out_driver = clk_sync[5]; // R16
    end else if (sel == smc_pkg::SEL_CONV_A) begin
      next_clock_out_driver = clk_sync[6]; // R16
    end else if (sel == smc_pkg::SEL_CONV_B) begin
      next_clock_out_driver = clk_sync[7]; // R16
    end else if (sel < smc_pkg::SEL_OSC_OUT) begin
      next_clock_out_driver = clk_sync[5'd7 + sel]; // R17
    end else if (sel < smc_pkg::SEL_CONV_A) begin
      // Codes 9..15 sit on test clock bits 6..12, sync bits 14..20
      next_clock_out_driver = clk_sync[sel + 5'd5]; // R17
    end
  end

  // Port B pins 7..4: GPIO enable wins, then address or alternate clock
  always_comb begin
    logic [3:0] alt_clk;
    logic [3:0] alt_sel;
    alt_clk = {clk_sync[2], clk_sync[1], clk_sync[0], clk_sync[3]};
    alt_sel = clock_out_select[smc_pkg::CO_PB_ALT_LSB +: 4];
    for (int i = 0; i < 4; i++) begin
      if (!PORT_B_PERIPHERAL_ENABLE[i]) begin
        next_pb[i] = PORT_B_GPIO_OUT[i]; // R9
      end else begin
        // Bit 3 R10, bit 2 R11, bit 1 R12, bit 0 R13
        next_pb[i] = alt_sel[i] ? alt_clk[i] : HIGH_ADDRESS[i]; // R9
      end
    end
  end

  always_ff @(posedge MCLK or posedge any_rst) begin
    if (any_rst) begin
      PORT_B_OUT <= 4'h0;
      CLOCK_OUT_PIN_O <= 1'b0;
      CLOCK_OUT_PIN_OE <= 1'b0;
      PULLUP_OFF <= 16'h0000;
    end else begin
      PORT_B_OUT <= next_pb; // R10 R11 R12 R13
      CLOCK_OUT_PIN_O <= next_clock_out_driver;
      CLOCK_OUT_PIN_OE <= ~clock_out_select[smc_pkg::CO_TRISTATE]; // R15
      PULLUP_OFF <= pullup_disable; // R5 R6 R7
    end
  end

endmodule

// >>> verification/smc_regs_assertions.sv
// Purpose: port checks for the system integration registers
// Assumes: answer in the cycle after setup, outputs one flop late
// Notes: bound to every smc_regs instance
`timescale 1ns/1ps
module smc_regs_chk #(
  parameter logic [15:0] CHIP_ID_UPPER = 16'h0a5a,
  parameter logic [15:0] CHIP_ID_LOWER = 16'h5a0a
) (
  // Clock and resets
  input wire logic MCLK,
  input wire logic RST,
  input wire logic POR_RST,
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Pins
  input wire logic [3:0] PORT_B_PERIPHERAL_ENABLE,
  input wire logic [3:0] PORT_B_GPIO_OUT,
  input wire logic [3:0] PORT_B_OUT,
  input wire logic CLOCK_OUT_PIN_OE,
  input wire logic [15:0] PULLUP_OFF
);
  wire setup = PSEL && !PENABLE;
  wire wr_done = PSEL && PENABLE && PREADY && PWRITE;
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST || POR_RST);
  a_ready_next:
    assert property (setup |=> PREADY) else $error("no ready");
  a_ready_only:
    assert property (!setup |=> !PREADY) else $error("stray ready");
  a_err_unmapped:
    assert property (setup && (PADDR[1:0] != 2'h0 || PADDR == 12'h024)
      |=> PSLVERR && PRDATA == 32'h0000_0000) else $error("no refusal");
  a_id_upper:
    assert property (setup && !PWRITE && PADDR == 12'h018 |=>
      PRDATA == {16'h0000, CHIP_ID_UPPER}) else $error("upper id");
  a_id_lower:
    assert property (setup && !PWRITE && PADDR == 12'h01c |=>
      PRDATA == {16'h0000, CHIP_ID_LOWER}) else $error("lower id");
  a_pu_write:
    assert property (wr_done && PADDR == 12'h020 |-> ##2
      {16'h0000, PULLUP_OFF} == ($past(PWDATA, 2) & 32'h0000_7fa8))
      else $error("pull-up out");
  a_oe_write:
    assert property (wr_done && PADDR == 12'h028 |-> ##2
      CLOCK_OUT_PIN_OE != $past(PWDATA[5], 2)) else $error("oe");
  a_gpio_first:
    assert property (!$past(RST) && !$past(POR_RST) |->
      (PORT_B_OUT & ~$past(PORT_B_PERIPHERAL_ENABLE)) ==
      ($past(PORT_B_GPIO_OUT) & ~$past(PORT_B_PERIPHERAL_ENABLE)))
      else $error("gpio path");
  a_oe_reset:
    assert property (@(posedge MCLK) disable iff (POR_RST)
      $fell(RST) |-> !CLOCK_OUT_PIN_OE [*2]) else $error("oe reset");
  a_pu_reserved:
    assert property ((PULLUP_OFF & 16'h8057) == 16'h0000)
      else $error("reserved set");
endmodule

bind smc_regs smc_regs_chk #(.CHIP_ID_UPPER(CHIP_ID_UPPER),
  .CHIP_ID_LOWER(CHIP_ID_LOWER)) smc_regs_chk_i (.*);

// >>> verification/smc_regs_tb_top.sv
// Purpose: self-checking bench for the system integration registers
// Assumes: static levels stand in for the sampled clocks
// Notes: clock-out sources sit in src, indexed by select code
`timescale 1ns/1ps
module smc_regs_tb_top;
  localparam logic [15:0] ID_HI = 16'h0c3c; // Arbitrary value
  localparam logic [15:0] ID_LO = 16'h3c0c; // Arbitrary value
  typedef struct packed {
    logic [11:0] a;
    logic [15:0] d;
    logic [32:0] e;
  } smc_row_type;
  logic mclk = 0, rst = 1, por = 1, psel = 0, pen = 0, pwr = 0, err;
  logic pready, pslverr, co_o, co_oe;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, src = 0;
  logic [3:0] pb_en = 0, pb_gpio = 0, hi_addr = 0, pb_clk = 0, pb_out;
  logic [15:0] pu_off;
  int mismatches = 0, check_count = 0;
  smc_row_type rows [10] = '{
    '{12'h008, 16'ha5c3, 33'h0_0000_a5c3},
    '{12'h00c, 16'h1234, 33'h0_0000_1234},
    '{12'h010, 16'hffff, 33'h0_0000_ffff},
    '{12'h014, 16'h8001, 33'h0_0000_8001},
    '{12'h018, 16'hffff, {17'h0_0000, ID_HI}},
    '{12'h01c, 16'h0000, {17'h0_0000, ID_LO}},
    '{12'h020, 16'hffff, 33'h0_0000_7fa8},
    '{12'h028, 16'hfc00, 33'h0_0000_0000},
    '{12'h024, 16'h0001, 33'h1_0000_0000},
    '{12'h00a, 16'h0001, 33'h1_0000_0000}};
  smc_regs #(.CHIP_ID_UPPER(ID_HI), .CHIP_ID_LOWER(ID_LO)) smc_regs_i (
    .MCLK(mclk), .RST(rst), .POR_RST(por), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .PORT_B_PERIPHERAL_ENABLE(pb_en),
    .PORT_B_GPIO_OUT(pb_gpio), .HIGH_ADDRESS(hi_addr),
    .PORT_B_OUT(pb_out), .SYSTEM_CLOCK(src[0]),
    .SECONDARY_SYSTEM_CLOCK(pb_clk[2]), .RAW_OSCILLATOR_CLOCK(pb_clk[3]),
    .PRESCALER_REFERENCE_CLOCK(pb_clk[0]), .OSC_OUT_CLOCK(src[7]),
    .PLL_OUT_CLOCK(src[8]), .CONV_A_CLOCK(src[16]),
    .CONV_B_CLOCK(src[17]), .TEST_CLOCKS({src[15:9], src[6:1]}),
    .CLOCK_OUT_PIN_O(co_o), .CLOCK_OUT_PIN_OE(co_oe), .PULLUP_OFF(pu_off));
  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [15:0] d);
    @(posedge mclk);
    psel <= 1'h1;
    pen <= 1'h0;
    paddr <= a;
    pwr <= w;
    pwdata <= {16'h0000, d};
    @(posedge mclk);
    pen <= 1'h1;
    for (int n = 0; n < 16; n++) begin
      @(posedge mclk);
      if (pready === 1'h1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask
  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic pulse(input bit use_por);
    if (use_por) begin
      por <= 1'h1;
    end else begin
      rst <= 1'h1;
    end
    repeat (2) @(posedge mclk);
    if (use_por) begin
      por <= 1'h0;
    end else begin
      rst <= 1'h0;
    end
  endtask
  initial begin
    forever #20 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    tally_and_finish();
  end
  initial begin
    pb_en = 4'hf;
    hi_addr = 4'h5;
    pb_gpio = 4'h6;
    src = 32'h0000_0001;
    pb_clk = 4'h8;
    repeat (2) @(posedge mclk);
    rst <= 1'h0;
    por <= 1'h0;
    apb(12'h028, 1'h0, 16'h0000);
    chk({err, rd}, 33'h0_0000_0020);
    chk({29'h0, pb_out}, 33'h5);
    for (int i = 0; i < 10; i++) begin
      apb(rows[i].a, 1'h1, rows[i].d);
      chk({err, rd}, {rows[i].e[32], 32'h0});
      apb(rows[i].a, 1'h0, 16'h0000);
      chk({err, rd}, rows[i].e);
    end
    chk({17'h0, pu_off}, 33'h7fa8);
    pulse(1'b0);
    apb(12'h008, 1'h0, 16'h0000);
    chk({err, rd}, 33'ha5c3);
    apb(12'h020, 1'h0, 16'h0000);
    chk({err, rd}, 33'h0);
    pulse(1'b1);
    apb(12'h008, 1'h0, 16'h0000);
    chk({err, rd}, 33'h0);
    apb(12'h028, 1'h1, 16'h03e0);
    repeat (6) @(posedge mclk);
    chk({29'h0, pb_out}, 33'ha);
    pb_en <= 4'h0;
    pb_gpio <= 4'h3;
    repeat (3) @(posedge mclk);
    chk({29'h0, pb_out}, 33'h3);
    for (int c = 0; c < 32; c++) begin
      src <= (c < 18) ? 32'h0000_0001 << c : 32'hffff_ffff;
      apb(12'h028, 1'h1, 16'(c));
      repeat (6) @(posedge mclk);
      chk({31'h0, co_oe, co_o}, {31'h0, 1'h1, c < 18});
    end
    apb(12'h028, 1'h1, 16'h0020);
    repeat (3) @(posedge mclk);
    chk({32'h0, co_oe}, 33'h0);
    tally_and_finish();
  end
endmodule
